// ===== cpu_addr_pkg.sv
package cpu_addr_pkg;
    localparam int PC_W          = 15;
    localparam int PM_ADDR_W     = 15;
    localparam int DM_ADDR_W     = 12;
    localparam int NIB_W         = 4;
    localparam int BYTE_W        = 8;
    localparam logic [14:0] RESET_HI_ADDR  = 15'h0000;
    localparam logic [14:0] RESET_LO_ADDR  = 15'h0001;
    localparam logic [14:0] VEC_FIRST_ADDR = 15'h0002;
    localparam logic [14:0] VEC_LAST_ADDR  = 15'h000F;
    localparam logic [14:0] TBL_FIRST_ADDR = 15'h0020;
    localparam logic [14:0] TBL_LAST_ADDR  = 15'h007F;
    localparam logic [14:0] PM_LAST_ADDR   = 15'h7F7F;
    localparam logic [14:0] HANDLER_LIMIT  = 15'h3FFF;
    localparam int MBE_BIT       = 7;
    localparam int RBE_BIT       = 6;
    localparam int PCHI_LSB_W    = 6;
    localparam logic [4:0] REL_NEG_MIN = 5'h0F;
    localparam logic [4:0] REL_POS_MAX = 5'h10;
    localparam logic [4:0] REL_POS_MIN = 5'h02;
    localparam logic [11:0] SP_ADDR    = 12'hF80;
    localparam logic [11:0] SBS_ADDR   = 12'hF84;
    localparam logic [11:0] RAM_LAST   = 12'h3FF;
    localparam logic [11:0] B1_LO      = 12'h100;
    localparam logic [11:0] DISP_FIRST = 12'h1A0;
    localparam logic [11:0] DISP_LAST  = 12'h1FF;
    localparam logic [11:0] DIGIT_ADDR = 12'h1FF;
    localparam logic [3:0]  SBS_HI_MASK = 4'h3;
    localparam logic [7:0]  SP_TOP     = 8'hFF;
    typedef enum logic [2:0] {
        PC_NOP, PC_INC, PC_FAR, PC_REL, PC_LOW8, PC_VEC
    } pc_op_t;
    typedef enum {
        ST_RESET_HI, ST_RESET_LO, ST_RUN
    } boot_state_t;
endpackage

// ===== cpu_addr_core.sv
`timescale 1ns/1ps
// Overview of operation
// - Program counter is a 15-bit counter addressing program memory.
// - Reset loads counter bits 13..8 from byte 0000H, bits 7..0 from 0001H.
// - Reset sets memory bank flag from bit 7, register flag from bit 6.
// - Interrupt vectors, flags and start address come from even bytes 0002H to 0010H.
// - Vectored interrupt loads both bank flags from its table entry.
// - Program memory spans 0000H..7F7FH; far jumps and calls reach it all.
// - Relative branch reaches PC-15..PC-1 and PC+2..PC+16, no block limits.
// - One-byte table call fetches its entries from 0020H..009FH.
// - Low-byte jumps via DE or XA replace only counter bits 7..0.
// - RAM: 1024 nibbles, 256 in each of banks 0 to 3.
// - Data memory is 4 bits wide; byte access needs even address.
// - Display memory at 1A0H..1FFH is plain RAM, digit port at top.
// - Four register banks of eight 4-bit registers mapped into RAM.
// - Active register bank is expand flag ANDed with bank choice.
// - BC, DE, HL, XA pairs act as bytes; DL, DE, HL are pointers.
// - Register locations stay reachable as ordinary RAM.
// - A is nibble accumulator, XA byte accumulator, carry bit accumulator.
// - Stack pointer decrements before a write, increments after a read.
// - Stack bank choice forces upper two bits to zero, low two pick bank.
// - With pointer at 00H the first push writes nFFH of bank n.
// - Stack wraps within its bank; only a new bank choice moves it.
// - Pointer is read and written as a byte, bank choice as a nibble.
// - Reset leaves stack pointer and bank choice undefined.
module cpu_addr_core (
    input  wire logic                      sys_clk,
    input  wire logic                      rst,
    output logic [cpu_addr_pkg::PM_ADDR_W-1:0] pm_addr,
    input  wire logic [7:0]                pm_data,
    input  wire cpu_addr_pkg::pc_op_t      pc_op,
    input  wire logic [14:0]               far_target,
    input  wire logic [4:0]                rel_offset,
    input  wire logic                      rel_backward,
    input  wire logic                      low8_from_xa,
    input  wire logic [2:0]                vec_index,
    input  wire logic [6:0]                table_index,
    input  wire logic                      table_fetch,
    output logic [14:0]                    table_addr,
    output logic [14:0]                    program_counter,
    output logic                           booting,
    output logic                           memory_bank_expand_flag,
    output logic                           register_bank_expand_flag,
    input  wire logic [1:0]                register_bank_choice,
    output logic [1:0]                     active_bank,
    input  wire logic                      flag_wr,
    input  wire logic                      mbe_wr_val,
    input  wire logic                      rbe_wr_val,
    input  wire logic                      carry_set,
    input  wire logic                      carry_wr,
    output logic                           carry_bit,
    input  wire logic [11:0]               dm_addr,
    input  wire logic                      dm_wr,
    input  wire logic                      dm_rd,
    input  wire logic                      dm_wide,
    input  wire logic                      dm_bit_op,
    input  wire logic [1:0]                dm_bit_sel,
    input  wire logic [7:0]                dm_wdata,
    output logic [7:0]                     dm_rdata,
    output logic                           dm_align_err,
    input  wire logic [2:0]                reg_sel,
    input  wire logic                      reg_wr,
    input  wire logic                      reg_wide,
    input  wire logic [7:0]                reg_wdata,
    output logic [7:0]                     reg_rdata,
    output logic [7:0]                     wide_accumulator_pair,
    input  wire logic                      stack_push,
    input  wire logic                      stack_pop,
    input  wire logic [3:0]                stack_wdata,
    output logic [3:0]                     stack_rdata,
    output logic [3:0]                     digit_drive_port
);
    import cpu_addr_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    boot_state_t  boot_r;
    logic [14:0]  pc_r;
    logic [14:0]  pc_nxt;
    logic [5:0]   pc_hi_r;
    logic         mbe_r;
    logic         rbe_r;
    logic         cy_r;
    logic [7:0]   sp_r;
    logic [3:0]   sbs_r;
    logic [3:0]   ram [0:1023];
    logic [7:0]   dm_rdata_r;
    logic [7:0]   reg_rdata_r;
    logic [7:0]   xa_r;
    logic [3:0]   stack_rdata_r;
    logic [3:0]   digit_r;
    logic [7:0]   sp_dec;
    logic [9:0]   stack_wr_addr;
    logic [9:0]   stack_rd_addr;
    logic [14:0]  rel_mag;
    logic         rel_ok;

    function automatic logic [9:0] reg_loc(input logic [1:0] bank,
                                           input logic [2:0] sel);
        // Registers sit in bank 0 data memory, eight nibbles per bank.
        reg_loc = {5'h00, bank, sel};
    endfunction

    function automatic logic in_ram(input logic [11:0] a);
        in_ram = (a <= RAM_LAST);
    endfunction

    assign active_bank = {2{register_bank_expand_flag}}
                         & register_bank_choice;
    assign rel_mag = {10'h000, rel_offset};

    // A relative branch outside its reach is refused and the counter holds.
    always_comb begin
        if (rel_backward) begin
            rel_ok = (rel_offset != '0) && (rel_offset <= REL_NEG_MIN);
        end else begin
            rel_ok = (rel_offset >= REL_POS_MIN)
                     && (rel_offset <= REL_POS_MAX);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Boot sequence reads the two reset vector bytes from program memory.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            boot_r <= ST_RESET_HI;
        end else begin
            case (boot_r)
                ST_RESET_HI: boot_r <= ST_RESET_LO;
                ST_RESET_LO: boot_r <= ST_RUN;
                default:     boot_r <= ST_RUN;
            endcase
        end
    end

    // Vector and table fetches borrow the program memory port for a cycle.
    always_comb begin
        pm_addr = pc_r;
        if (boot_r == ST_RESET_HI) begin
            pm_addr = RESET_HI_ADDR;
        end else if (boot_r == ST_RESET_LO) begin
            pm_addr = RESET_LO_ADDR;
        end else if (pc_op == PC_VEC) begin
            pm_addr = VEC_FIRST_ADDR + {11'h000, vec_index, 1'b0};
        end else if (table_fetch) begin
            pm_addr = table_addr;
        end
    end

    assign table_addr = TBL_FIRST_ADDR + {8'h00, table_index};
    assign booting    = (boot_r != ST_RUN);

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        pc_nxt = pc_r;
        case (pc_op)
            PC_INC:  pc_nxt = pc_r + 15'h0001;
            PC_FAR:  pc_nxt = far_target;
            PC_REL:  pc_nxt = !rel_ok      ? pc_r
                            : rel_backward ? pc_r - rel_mag
                                           : pc_r + rel_mag;
            PC_LOW8: pc_nxt = {pc_r[14:8], low8_from_xa ? xa_r
                               : reg_rdata_r};
            PC_VEC:  pc_nxt = {1'b0, pm_data[PCHI_LSB_W-1:0],
                               8'h00};
            default: pc_nxt = pc_r;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pc_r    <= '0;
            pc_hi_r <= '0;
        end else if (boot_r == ST_RESET_HI) begin
            pc_hi_r <= pm_data[PCHI_LSB_W-1:0];
        end else if (boot_r == ST_RESET_LO) begin
            pc_r <= {1'b0, pc_hi_r, pm_data};
        end else if (pc_nxt <= PM_LAST_ADDR) begin
            pc_r <= pc_nxt;
        end
    end
    assign program_counter = pc_r;

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            mbe_r <= 1'b0;
            rbe_r <= 1'b0;
        end else if (boot_r == ST_RESET_HI) begin
            mbe_r <= pm_data[MBE_BIT];
            rbe_r <= pm_data[RBE_BIT];
        end else if (boot_r == ST_RUN && pc_op == PC_VEC) begin
            mbe_r <= pm_data[MBE_BIT];
            rbe_r <= pm_data[RBE_BIT];
        end else if (flag_wr) begin
            mbe_r <= mbe_wr_val;
            rbe_r <= rbe_wr_val;
        end
    end
    assign memory_bank_expand_flag   = mbe_r;
    assign register_bank_expand_flag = rbe_r;

    // The carry bit keeps no reset value, so it is undefined after reset.
    always_ff @(posedge sys_clk) begin
        if (carry_wr) begin
            cy_r <= carry_set;
        end
    end
    assign carry_bit = cy_r;

    ////////////////////////////////////////////////////////////////////////
    // Stack pointer and bank choice hold no reset value.
    assign sp_dec        = sp_r - 8'h01;
    assign stack_wr_addr = {sbs_r[1:0], sp_dec};
    assign stack_rd_addr = {sbs_r[1:0], sp_r};

    always_ff @(posedge sys_clk) begin
        if (stack_push) begin
            sp_r <= sp_dec;
        end else if (stack_pop) begin
            sp_r <= sp_r + 8'h01;
        end else if (dm_wr && dm_wide && dm_addr == SP_ADDR) begin
            sp_r <= {dm_wdata[7:1], 1'b0};
        end
    end

    // All four bits are stored with the upper two cleared, so they read as zero once a bank choice is written.
    always_ff @(posedge sys_clk) begin
        if (dm_wr && !dm_wide && dm_addr == SBS_ADDR) begin
            sbs_r <= dm_wdata[3:0] & SBS_HI_MASK;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign dm_align_err = (dm_rd | dm_wr) & dm_wide & dm_addr[0];

    always_ff @(posedge sys_clk) begin
        if (stack_push) begin
            ram[stack_wr_addr] <= stack_wdata;
        end else if (reg_wr) begin
            ram[reg_loc(active_bank, reg_sel)] <= reg_wdata[3:0];
            if (reg_wide) begin
                ram[reg_loc(active_bank, reg_sel | 3'h1)]
                    <= reg_wdata[7:4];
            end
        end else if (dm_wr && in_ram(dm_addr) && !dm_align_err) begin
            if (dm_bit_op) begin
                ram[dm_addr[9:0]][dm_bit_sel] <= dm_wdata[0];
            end else begin
                ram[dm_addr[9:0]] <= dm_wdata[3:0];
                if (dm_wide) begin
                    ram[dm_addr[9:0] | 10'h001] <= dm_wdata[7:4];
                end
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            digit_r <= '0;
        end else if (dm_wr && !dm_wide && dm_addr == DIGIT_ADDR) begin
            if (dm_bit_op) begin
                digit_r[dm_bit_sel] <= dm_wdata[0];
            end else begin
                digit_r <= dm_wdata[3:0];
            end
        end
    end
    assign digit_drive_port = digit_r;

    // Read data is registered; dm_rdata stands until the next read, the others reload every cycle.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            dm_rdata_r    <= '0;
            reg_rdata_r   <= '0;
            stack_rdata_r <= '0;
            xa_r          <= '0;
        end else begin
            stack_rdata_r <= ram[stack_rd_addr];
            reg_rdata_r   <= {ram[reg_loc(active_bank, reg_sel | 3'h1)],
                              ram[reg_loc(active_bank, reg_sel & 3'h6)]};
            xa_r          <= {ram[reg_loc(active_bank, 3'h7)],
                              ram[reg_loc(active_bank, 3'h6)]};
            if (dm_rd) begin
                if (dm_addr == SP_ADDR) begin
                    dm_rdata_r <= sp_r;
                end else if (dm_addr == SBS_ADDR) begin
                    dm_rdata_r <= {4'h0, sbs_r};
                end else if (in_ram(dm_addr)) begin
                    dm_rdata_r <= {dm_wide ? ram[dm_addr[9:0] | 10'h001]
                                           : 4'h0,
                                   ram[dm_addr[9:0]]};
                end else begin
                    dm_rdata_r <= '0;
                end
            end
        end
    end
    assign dm_rdata              = dm_rdata_r;
    assign reg_rdata             = reg_rdata_r;
    assign wide_accumulator_pair = xa_r;
    assign stack_rdata           = stack_rdata_r;

endmodule // cpu_addr_core

// ===== cpu_addr_checker.sv
`timescale 1ns/1ps
module cpu_addr_checker
    import cpu_addr_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic [14:0] pm_addr,
    input wire logic [7:0]  pm_data,
    input wire pc_op_t      pc_op,
    input wire logic [14:0] far_target,
    input wire logic [6:0]  table_index,
    input wire logic [14:0] table_addr,
    input wire logic [14:0] program_counter,
    input wire logic        booting,
    input wire logic        memory_bank_expand_flag,
    input wire logic        register_bank_expand_flag,
    input wire logic [1:0]  register_bank_choice,
    input wire logic [1:0]  active_bank,
    input wire logic [11:0] dm_addr,
    input wire logic        dm_wr,
    input wire logic        dm_wide,
    input wire logic        dm_bit_op,
    input wire logic [7:0]  dm_wdata,
    input wire logic        stack_push,
    input wire logic        stack_pop,
    input wire logic [3:0]  stack_wdata,
    input wire logic [3:0]  stack_rdata,
    input wire logic [3:0]  digit_drive_port
);
default clocking cb @(posedge sys_clk); endclocking
default disable iff (rst);
logic [7:0] hi_r;
// Holds the first boot byte so the load can be judged one fetch later.
always_ff @(posedge sys_clk) begin
    if (booting && pm_addr == RESET_HI_ADDR) begin
        hi_r <= pm_data;
    end
end
sequence s_boot;
    booting && pm_addr == RESET_HI_ADDR ##1 booting && pm_addr == RESET_LO_ADDR;
endsequence
sequence s_push_pop;
    stack_push && !dm_wr ##1 stack_pop && !stack_push && !dm_wr;
endsequence
property p_boot; $fell(rst) |-> s_boot ##1 !booting; endproperty
property p_load;
    booting && pm_addr == RESET_LO_ADDR |=>
        program_counter == {1'b0, hi_r[5:0], $past(pm_data)} &&
        memory_bank_expand_flag == hi_r[MBE_BIT] &&
        register_bank_expand_flag == hi_r[RBE_BIT];
endproperty
property p_inc;
    !booting && pc_op == PC_INC && program_counter < PM_LAST_ADDR |=>
        program_counter == $past(program_counter) + 15'h0001;
endproperty
property p_far;
    !booting && pc_op == PC_FAR && far_target <= PM_LAST_ADDR |=>
        program_counter == $past(far_target);
endproperty
property p_bank;
    active_bank == ({2{register_bank_expand_flag}} & register_bank_choice);
endproperty
property p_tbl; table_addr == TBL_FIRST_ADDR + {8'h00, table_index}; endproperty
property p_lifo; s_push_pop |=> stack_rdata == $past(stack_wdata, 2); endproperty
property p_digit;
    dm_wr && !dm_wide && !dm_bit_op && dm_addr == DIGIT_ADDR |=>
        {4'h0, digit_drive_port} == ($past(dm_wdata) & 8'h0F);
endproperty
a_boot: assert property (p_boot) else $error("boot fetch order wrong");
a_load: assert property (p_load) else $error("boot load wrong");
a_inc: assert property (p_inc) else $error("counter step wrong");
a_far: assert property (p_far) else $error("far jump wrong");
a_bank: assert property (p_bank) else $error("active bank wrong");
a_tbl: assert property (p_tbl) else $error("table address wrong");
a_lifo: assert property (p_lifo) else $error("stack order wrong");
a_digit: assert property (p_digit) else $error("digit port wrong");
endmodule // cpu_addr_checker
bind cpu_addr_core cpu_addr_checker chk (.sys_clk, .rst, .pm_addr, .pm_data,
    .pc_op, .far_target, .table_index, .table_addr, .program_counter, .booting,
    .memory_bank_expand_flag, .register_bank_expand_flag, .register_bank_choice,
    .active_bank, .dm_addr, .dm_wr, .dm_wide, .dm_bit_op, .dm_wdata,
    .stack_push, .stack_pop, .stack_wdata, .stack_rdata, .digit_drive_port);

// ===== cpu_pc_stack_and_register_banks_tb_top.sv
`timescale 1ns/1ps
module cpu_pc_stack_and_register_banks_tb_top;
import cpu_addr_pkg::*;
typedef struct {int due; int id; logic [15:0] v;} note_t;
logic sys_clk, rst, booting, memory_bank_expand_flag, register_bank_expand_flag;
logic rel_backward, low8_from_xa, table_fetch, flag_wr, mbe_wr_val, rbe_wr_val;
logic carry_set, carry_wr, carry_bit, dm_wr, dm_rd, dm_wide, dm_bit_op;
logic dm_align_err, reg_wr, reg_wide, stack_push, stack_pop;
logic [14:0] pm_addr, far_target, table_addr, program_counter, pc_e;
logic [11:0] dm_addr;
logic [7:0]  pm_data, dm_wdata, dm_rdata, reg_wdata, reg_rdata, b0, b1, v, w;
logic [7:0]  wide_accumulator_pair;
logic [6:0]  table_index;
logic [4:0]  rel_offset;
logic [3:0]  stack_wdata, stack_rdata, digit_drive_port, d;
logic [2:0]  vec_index, reg_sel;
logic [1:0]  register_bank_choice, active_bank, dm_bit_sel;
logic [15:0] o;
logic [31:0] seed = 32'h0000B19B;
logic [14:0] tg [3] = '{15'h0000, 15'h7F7F, 15'h2A5C};
pc_op_t      pc_op;
int          error_cnt = 0, compares = 0, cyc = 0;
note_t       q[$];
string nm[13] = '{"pc", "flags", "bank", "table", "dm_rdata", "stack_rdata",
                  "digit", "reg_rdata", "xa", "align", "carry", "dm_nibble",
                  "pm_addr"};
assign pm_data = pm_addr == 15'h0 ? b0 : pm_addr == 15'h1 ? b1 : 8'h5A;
cpu_addr_core uut (.*);
initial begin
    sys_clk = 0;
    forever #5 sys_clk = ~sys_clk;
end
always @(posedge sys_clk) cyc <= cyc + 1;
function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
endfunction
task automatic step(); @(negedge sys_clk); endtask
task automatic ex(int id, logic [15:0] val, int dl); q.push_back('{cyc + dl, id, val}); endtask
task automatic idle();
    {dm_wr, dm_rd, dm_wide, reg_wr, reg_wide, stack_push, stack_pop} = '0;
    {flag_wr, carry_wr, table_fetch, low8_from_xa} = '0;
    pc_op = PC_NOP;
endtask
task automatic check(string n, logic [15:0] s, logic [15:0] e);
    compares++;
    if (s !== e) begin
        error_cnt++;
        $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
endtask
task automatic close_out();
    if (q.size() > 0) error_cnt++;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
endtask
always @(negedge sys_clk) begin
    #1;
    while (q.size() > 0 && q[0].due <= cyc) begin
        case (q[0].id)
            0: o = 16'(program_counter);
            1: o = 16'({memory_bank_expand_flag, register_bank_expand_flag});
            2: o = 16'(active_bank);
            3: o = 16'(table_addr);
            4: o = 16'(dm_rdata);
            5: o = 16'(stack_rdata);
            6: o = 16'(digit_drive_port);
            7: o = 16'(reg_rdata);
            8: o = 16'(wide_accumulator_pair);
            9: o = 16'(dm_align_err);
            10: o = 16'(carry_bit);
            11: o = 16'(dm_rdata[3:0]);
            default: o = 16'(pm_addr);
        endcase
        check(nm[q[0].id], o, q[0].v);
        void'(q.pop_front());
    end
end
task automatic do_reset();
    int n;
    b0 = 8'(rnd());
    b1 = 8'(rnd());
    rst = 1;
    repeat (3) step();
    rst = 0;
    n = 0;
    do begin step(); n++; end while (booting !== 1'b0 && n < 10);
    if (n >= 10) begin error_cnt++; close_out(); end
    pc_e = {1'b0, b0[5:0], b1};
    ex(0, 16'(pc_e), 0);
    ex(1, 16'(b0[7:6]), 0);
    $display("test reset done");
endtask
initial begin
    rst = 1;
    {far_target, rel_offset, rel_backward, vec_index, table_index} = '0;
    {register_bank_choice, mbe_wr_val, rbe_wr_val, carry_set, dm_addr} = '0;
    {dm_bit_op, dm_bit_sel, dm_wdata, reg_sel, reg_wdata, stack_wdata} = '0;
    {b0, b1} = '0;
    idle();
    for (int r = 0; r < 2; r++) do_reset();
    step(); pc_op = PC_INC; ex(0, 16'(pc_e + 15'h1), 1);
    foreach (tg[i]) begin
        step(); pc_op = PC_FAR; far_target = tg[i]; ex(0, 16'(tg[i]), 1);
    end
    step(); far_target = 15'h7FF0; ex(0, 16'h2A5C, 1);
    pc_e = 15'h2A5C;
    for (int k = 0; k < 6; k++) begin
        step(); pc_op = PC_REL; rel_backward = k > 1 ? 1'(rnd()) : 1'b0;
        rel_offset = k > 1 ? 5'(rnd()) : 5'(5'h10 + k);
        if (rel_backward && rel_offset inside {[1:15]})
            pc_e = pc_e - 15'(rel_offset);
        else if (!rel_backward && rel_offset inside {[2:16]})
            pc_e = pc_e + 15'(rel_offset);
        ex(0, 16'(pc_e), 1);
    end
    step(); pc_op = PC_VEC; vec_index = 3'(rnd());
    ex(12, 16'(15'h0002 + {vec_index, 1'b0}), 0);
    ex(0, 16'({1'b0, 6'h1A, 8'h00}), 1);
    ex(1, 16'h0001, 1);
    step(); pc_op = PC_FAR; far_target = 15'h1234; ex(0, 16'h1234, 1);
    $display("test counter done");
    v = 8'(rnd());
    w = 8'(rnd());
    step(); idle(); flag_wr = 1; rbe_wr_val = 0; mbe_wr_val = 1;
    step(); idle(); reg_wr = 1; reg_wide = 1; reg_sel = 3'd6; reg_wdata = v;
    ex(8, 16'(v), 2);
    step(); reg_sel = 3'd2; reg_wdata = w;
    step(); reg_wr = 0; ex(7, 16'(w), 1);
    step(); pc_op = PC_LOW8; ex(0, {2'b0, 6'h12, w}, 1);
    step(); low8_from_xa = 1; ex(0, {2'b0, 6'h12, v}, 1);
    step(); idle(); dm_rd = 1; dm_wide = 1; dm_addr = 12'h006;
    ex(4, 16'(v), 1);
    for (int i = 0; i < 8; i++) begin
        step(); idle(); flag_wr = 1; rbe_wr_val = i[2];
        step(); flag_wr = 0; register_bank_choice = i[1:0];
        ex(2, 16'({2{i[2]}} & i[1:0]), 0);
    end
    for (int i = 0; i < 2; i++) begin
        step(); table_fetch = 1; table_index = i ? 7'h5F : 7'(rnd());
        ex(3, 16'(15'h0020 + table_index), 0);
        ex(12, 16'(15'h0020 + table_index), 0);
    end
    $display("test registers done");
    step(); idle(); dm_wr = 1; dm_wide = 1; dm_addr = SP_ADDR; dm_wdata = 8'h00;
    step(); dm_wide = 0; dm_addr = SBS_ADDR; dm_wdata = 8'h0E;
    step(); dm_wr = 0; dm_rd = 1; ex(11, 16'h2, 1);
    step(); dm_rd = 0; stack_push = 1; stack_wdata = 4'h5;
    step(); stack_push = 0; dm_rd = 1; dm_addr = 12'h2FF;
    ex(11, 16'h5, 1);
    step(); dm_wide = 1; dm_addr = SP_ADDR; ex(4, 16'hFF, 1);
    step(); idle(); stack_push = 1; stack_wdata = 4'h9;
    step(); stack_push = 0; stack_pop = 1; ex(5, 16'h9, 1);
    step(); ex(5, 16'h5, 1);
    step(); idle(); dm_rd = 1; dm_wide = 1; ex(4, 16'h00, 1);
    $display("test stack done");
    d = 4'(rnd());
    step(); idle(); dm_wr = 1; dm_addr = DIGIT_ADDR; dm_wdata = {4'h0, d};
    ex(6, 16'(d), 1);
    step(); dm_wide = 1; dm_addr = 12'h140; dm_wdata = 8'hA5;
    step(); dm_addr = 12'h141; dm_wdata = 8'h3C; ex(9, 16'h1, 0);
    step(); dm_wr = 0; dm_rd = 1; dm_addr = 12'h140; ex(4, 16'hA5, 1);
    step(); idle(); carry_wr = 1; carry_set = 1; ex(10, 16'h1, 1);
    step(); carry_set = 0; ex(10, 16'h0, 1);
    step(); idle();
    $display("test memory done");
    repeat (3) step();
    close_out();
end
endmodule // cpu_pc_stack_and_register_banks_tb_top
